/* logic/fault_regs_pkg.sv */
/*
  Shared constants for the channel fault status register bank:
  register offsets, command fields, reset values and timing counts.
  Assumes a 50 MHz core clock and an 8-bit command byte per frame.
*/
package fault_regs_pkg;

  // Channel count and register width
  localparam int NUM_CH     = 4;
  localparam int REG_W      = 8;
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS   = 8;

  // Register offsets (6-bit address field)
  localparam logic [5:0] ADDR_OFFSTATE = 6'h32;
  localparam logic [5:0] ADDR_PWL      = 6'h33;
  localparam logic [5:0] ADDR_OVL      = 6'h34;

  // Reset value of every status register
  localparam logic [REG_W-1:0] RESET_STATUS = 8'h00;

  // Command byte layout: opcode on top, address below
  localparam int OP_MSB   = 7;
  localparam int OP_LSB   = 6;
  localparam int ADDR_MSB = 5;
  localparam int ADDR_LSB = 0;

  // Opcodes
  localparam logic [1:0] OP_READ       = 2'h1;
  localparam logic [1:0] OP_READ_CLEAR = 2'h2;

  // Off-state detection delay and its cycle count (rounded up)
  localparam int CLK_PERIOD_NS            = 20;
  localparam int OFFSTATE_DETECT_DELAY_NS = 100000;
  localparam int OFFSTATE_DETECT_CYC      =
    (OFFSTATE_DETECT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Which status register an address selects
  typedef enum logic [1:0] {SEL_NONE, SEL_OFFSTATE, SEL_PWL, SEL_OVL} reg_sel_e;

  // Address decode, shared by the link side and the core side
  function automatic reg_sel_e decode_sel(input logic [5:0] addr);
    case (addr)
      ADDR_OFFSTATE: decode_sel = SEL_OFFSTATE;
      ADDR_PWL:      decode_sel = SEL_PWL;
      ADDR_OVL:      decode_sel = SEL_OVL;
      default:       decode_sel = SEL_NONE;
    endcase
  endfunction

endpackage

/* logic/bit_sync.sv */
/*
  Two-stage synchroniser for a bus of independent level signals.
  Assumes each bit may change at any time relative to clk_in.
*/
`timescale 1ns/1ps
module bit_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_ff;   // First stage, read only by the second
  logic [WIDTH-1:0] sync_ff;   // Second stage, safe to use

  // Two flops in a row; the reset value is a tie-off constant at the top
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_ff <= rst_val_in;
      sync_ff <= rst_val_in;
    end
    else
    begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;

endmodule // bit_sync

/* logic/offstate_delay_timer.sv */
/*
  Per-channel timer: counts core cycles since the channel went off and
  flags when the off-state detection delay has elapsed.
  Assumes chan_on_in is from the core clock domain.
*/
`timescale 1ns/1ps
module offstate_delay_timer
#(
  parameter int unsigned DELAY_CYC = 5000
)
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic chan_on_in,
  output logic      done_out
);

  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);

  logic [CW-1:0] cnt_ff;    // Cycles spent off
  logic          done_ff;   // Delay has elapsed

  // Restart on every on period, saturate once the delay is reached
  always_ff @(posedge clk_in)
  begin
    if (rst_in || chan_on_in)
    begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end
    else if (!done_ff)
    begin
      cnt_ff  <= cnt_ff + CW'(1);
      done_ff <= (cnt_ff == LAST);
    end
  end

  assign done_out = done_ff;

endmodule // offstate_delay_timer

/* logic/channel_fault_status_regs.sv */
/*
  Channel fault status register bank: off-state open-load / stuck,
  power limitation and overload status, read and cleared over SPI.
  Assumes: SPI mode 0, 16-bit frames (command byte, then data byte),
  detector inputs asynchronous, channel_on and config on clk_in.
*/
`timescale 1ns/1ps
module channel_fault_status_regs
  import fault_regs_pkg::*;
#(
  parameter int unsigned DELAY_CYC = OFFSTATE_DETECT_CYC
)
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              sck_in,
  input  wire logic              chip_select_n_in,
  input  wire logic              mosi_in,
  output logic                   miso_out,
  output logic                   miso_oe_out,
  input  wire logic [NUM_CH-1:0] channel_on_in,
  input  wire logic [NUM_CH-1:0] offstate_openload_config_in,
  input  wire logic [NUM_CH-1:0] offstate_openload_det_in,
  input  wire logic [NUM_CH-1:0] offstate_stuck_det_in,
  input  wire logic              latch_mode_in,
  input  wire logic [NUM_CH-1:0] power_limit_condition_in,
  input  wire logic [NUM_CH-1:0] overload_det_in,
  output logic [REG_W-1:0]       offstate_status_out,
  output logic [REG_W-1:0]       power_limit_status_out,
  output logic [REG_W-1:0]       overload_status_out
);

  // ---------------- Link (sck) domain ----------------

  logic [4:0]          bit_cnt_ff;    // Bits received this frame
  logic [CMD_BITS-1:0] cmd_sh_ff;     // Command byte being shifted in
  logic [CMD_BITS-1:0] cmd_ff;        // Last complete command
  logic                done_tgl_ff;   // Toggles once per full frame
  logic                miso_ff;       // Response bit on the pin
  logic [3:0]          resp_nib;      // Selected register, channel bits
  logic [REG_W-1:0]    resp_byte;     // Response byte with zero top
  logic [2:0]          resp_idx;      // Bit of the byte to send next
  reg_sel_e            link_sel;      // Register chosen by command
  logic [3*NUM_CH-1:0] snap_ff;       // Core snapshot, static during a frame

  // Shift in the command byte; chip select high ends the frame
  always_ff @(posedge sck_in or posedge chip_select_n_in)
  begin
    if (chip_select_n_in)
    begin
      bit_cnt_ff <= 5'h00;
      cmd_sh_ff  <= 8'h00;
    end
    else
    begin
      // Count saturates so overlong frames do nothing extra
      if (bit_cnt_ff != 5'(FRAME_BITS))
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      if (bit_cnt_ff < 5'(CMD_BITS))
        cmd_sh_ff <= {cmd_sh_ff[CMD_BITS-2:0], mosi_in};
    end
  end

  // Hand a full command to the core; needs rst_in since the link
  // clock may never run before the first frame
  always_ff @(posedge sck_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cmd_ff      <= 8'h00;
      done_tgl_ff <= 1'b0;
    end
    else if (!chip_select_n_in && bit_cnt_ff == 5'(FRAME_BITS - 1))
    begin
      cmd_ff      <= cmd_sh_ff;
      done_tgl_ff <= ~done_tgl_ff;
    end
  end

  // Pick the addressed register from the frozen snapshot
  always_comb
  begin
    link_sel = decode_sel(cmd_sh_ff[ADDR_MSB:ADDR_LSB]);
    case (link_sel)
      SEL_OFFSTATE: resp_nib = snap_ff[NUM_CH-1:0];
      SEL_PWL:      resp_nib = snap_ff[2*NUM_CH-1:NUM_CH];
      SEL_OVL:      resp_nib = snap_ff[3*NUM_CH-1:2*NUM_CH];
      default:      resp_nib = 4'h0;
    endcase
    // Reserved top bits always read zero
    resp_byte = {4'h0, resp_nib};
    resp_idx  = 3'(5'd15 - bit_cnt_ff);
  end

  // Drive response bits on the falling edge, MSB first, second byte
  always_ff @(negedge sck_in or posedge chip_select_n_in)
  begin
    if (chip_select_n_in)
      miso_ff <= 1'b0;
    else if (bit_cnt_ff >= 5'(CMD_BITS) && bit_cnt_ff < 5'(FRAME_BITS))
      miso_ff <= resp_byte[resp_idx];
    else
      miso_ff <= 1'b0;
  end

  assign miso_out = miso_ff;

  // ---------------- Core (clk) domain ----------------

  logic [4*NUM_CH-1:0] det_s;        // Synced detectors
  logic [1:0]          link_s;       // Synced chip select and toggle
  logic                cs_n_s;       // Synced chip select
  logic                tgl_s;        // Synced frame-done toggle
  logic                cs_prev_ff;   // Chip select, one cycle late
  logic                tgl_prev_ff;  // Toggle, one cycle late
  logic                cmd_pend_ff;  // Full command seen this frame
  logic                miso_oe_ff;   // Pin enable
  logic                frozen;       // Frame in progress
  logic                frame_start, frame_end, cmd_seen;  // Select edges, command arrival
  logic                rc_fire;      // Read-and-clear takes effect now
  reg_sel_e            core_sel;

  logic [NUM_CH-1:0] ol_s, stk_s, pwl_c, ovl_c;
  logic [NUM_CH-1:0] off_ff, pwl_ff, ovl_ff;
  logic [NUM_CH-1:0] pend_pwl_ff, pend_ovl_ff;  // Events held in a frame
  logic [NUM_CH-1:0] off_seen_ff;  // Turned off since overload set
  logic [NUM_CH-1:0] timer_done;
  logic [NUM_CH-1:0] off_sel, off_ready;
  logic [NUM_CH-1:0] clr_off, clr_pwl, clr_ovl;
  logic [NUM_CH-1:0] pwl_ev, ovl_ev;

  // Analog detector outputs are asynchronous to the core clock
  bit_sync #(.WIDTH(4*NUM_CH)) u_det_sync
  (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .d_in       ({overload_det_in, power_limit_condition_in,
                  offstate_stuck_det_in, offstate_openload_det_in}),
    .rst_val_in (16'h0000),
    .q_out      (det_s)
  );

  // Chip select idles high; toggle resets low like its source
  bit_sync #(.WIDTH(2)) u_link_sync
  (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .d_in       ({done_tgl_ff, chip_select_n_in}),
    .rst_val_in (2'b01),
    .q_out      (link_s)
  );

  assign {ovl_c, pwl_c, stk_s, ol_s} = det_s;
  assign cs_n_s = link_s[0];
  assign tgl_s  = link_s[1];

  // Per-channel off-state delay timers
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_timer
    offstate_delay_timer #(.DELAY_CYC(DELAY_CYC)) u_timer
    (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .chan_on_in (channel_on_in[ch]),
      .done_out   (timer_done[ch])
    );
  end

  // Frame edges and command arrival, all from synced levels
  always_comb
  begin
    frozen      = ~cs_n_s;
    frame_start = cs_prev_ff & ~cs_n_s;
    frame_end   = ~cs_prev_ff & cs_n_s;
    cmd_seen    = tgl_s ^ tgl_prev_ff;
    // The toggle may land in the same cycle as the frame end
    rc_fire     = frame_end & (cmd_pend_ff | cmd_seen) &
                  (cmd_ff[OP_MSB:OP_LSB] == OP_READ_CLEAR);
    core_sel    = decode_sel(cmd_ff[ADDR_MSB:ADDR_LSB]);
  end

  // Remember edges and whether a full command arrived
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cs_prev_ff  <= 1'b1;
      tgl_prev_ff <= 1'b0;
      cmd_pend_ff <= 1'b0;
    end
    else
    begin
      cs_prev_ff  <= cs_n_s;
      tgl_prev_ff <= tgl_s;
      if (frame_end)
        cmd_pend_ff <= 1'b0;
      else if (cmd_seen)
        cmd_pend_ff <= 1'b1;
    end
  end

  // Drive the data pin only inside a frame
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      miso_oe_ff <= 1'b0;
    else
      miso_oe_ff <= ~cs_n_s;
  end

  assign miso_oe_out = miso_oe_ff;

  // Freeze a copy at frame start; the link reads it while static
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      snap_ff <= 12'h000;
    else if (frame_start)
      snap_ff <= {ovl_ff, pwl_ff, off_ff};
  end

  // Clear masks and set events
  always_comb
  begin
    clr_off = (rc_fire && core_sel == SEL_OFFSTATE) ? snap_ff[NUM_CH-1:0] : 4'h0;
    clr_pwl = (rc_fire && core_sel == SEL_PWL) ? snap_ff[2*NUM_CH-1:NUM_CH] : 4'h0;
    clr_ovl = (rc_fire && core_sel == SEL_OVL) ? snap_ff[3*NUM_CH-1:2*NUM_CH] : 4'h0;
    off_sel   = (offstate_openload_config_in & stk_s) |
                (~offstate_openload_config_in & ol_s);
    off_ready = ~channel_on_in & timer_done;
    pwl_ev    = pwl_c | pend_pwl_ff;
    ovl_ev    = (ovl_c & channel_on_in) | pend_ovl_ff;
  end

  // Off-state open-load / stuck status
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      off_ff <= RESET_STATUS[NUM_CH-1:0];
    else if (!frozen)
      off_ff <= (off_ready & off_sel) |
                (~off_ready & off_ff & ~clr_off);
  end

  // Events inside a frame wait for its end
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pend_pwl_ff <= 4'h0;
      pend_ovl_ff <= 4'h0;
    end
    else if (frozen)
    begin
      pend_pwl_ff <= pend_pwl_ff | pwl_c;
      pend_ovl_ff <= pend_ovl_ff | (ovl_c & channel_on_in);
    end
    else
    begin
      pend_pwl_ff <= 4'h0;
      pend_ovl_ff <= 4'h0;
    end
  end

  // Power limitation status
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pwl_ff <= RESET_STATUS[NUM_CH-1:0];
    else if (!frozen)
    begin
      if (latch_mode_in)
        pwl_ff <= pwl_ev | (pwl_ff & ~clr_pwl);
      else
        pwl_ff <= pwl_ev | (pwl_ff & ~channel_on_in & ~clr_pwl);
    end
  end

  // Overload status; a clear needs a turn-off since the set
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ovl_ff <= RESET_STATUS[NUM_CH-1:0];
    else if (!frozen)
      ovl_ff <= ovl_ev | (ovl_ff & ~(clr_ovl & off_seen_ff));
  end

  // Turn-off tracking; one inside a frame is missed, the clear waits
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      off_seen_ff <= 4'h0;
    else if (!frozen)
      off_seen_ff <= ~ovl_ev & (off_seen_ff | ~channel_on_in);
  end

  assign offstate_status_out    = {4'h0, off_ff};
  assign power_limit_status_out = {4'h0, pwl_ff};
  assign overload_status_out    = {4'h0, ovl_ff};

  // ---------------- Checks ----------------

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  frozen_regs_a: assert property (frozen |=> $stable({off_ff, pwl_ff, ovl_ff}))
    else $error("status changed during a frame");
  offstate_hold_a: assert property (1'b1 |=>
    ((off_ff & ~$past(off_ff) & $past(channel_on_in)) == 4'h0))
    else $error("off-state bit rose while channel on");
  offstate_follow_a: assert property (!frozen |=>
    (((off_ff ^ $past(off_sel)) & $past(off_ready)) == 4'h0))
    else $error("off-state bit not following detector");
  reserved_zero_a: assert property ((offstate_status_out[7:4] |
    power_limit_status_out[7:4] | overload_status_out[7:4]) == 4'h0)
    else $error("reserved bits not zero");
  pwl_set_a: assert property (!frozen ##0 pwl_c != 4'h0 |=>
    ((pwl_ff & $past(pwl_c)) == $past(pwl_c)))
    else $error("power limit bit not set");
  pwl_latch_a: assert property (latch_mode_in && !rc_fire |=>
    ((~pwl_ff & $past(pwl_ff)) == 4'h0))
    else $error("latched power limit bit dropped");
  pwl_auto_a: assert property (!frozen && !latch_mode_in |=>
    ((pwl_ff & $past(channel_on_in & ~pwl_ev)) == 4'h0))
    else $error("auto-restart bit not cleared");
  ovl_set_a: assert property (!frozen |=>
    ((ovl_ff & $past(ovl_c & channel_on_in)) == $past(ovl_c & channel_on_in)))
    else $error("overload bit not set");
  ovl_hold_a: assert property (1'b1 |=>
    ((~ovl_ff & $past(ovl_ff & ~off_seen_ff)) == 4'h0))
    else $error("overload bit dropped before turn-off");
  rc_clear_a: assert property (rc_fire && core_sel == SEL_PWL |=>
    ((pwl_ff & $past(snap_ff[7:4] & ~pwl_ev)) == 4'h0))
    else $error("read-and-clear left a reported bit");

endmodule // channel_fault_status_regs

/* bench/spi_host_model.sv */
/*
  Behavioural SPI host that issues one 16-bit frame per call of frame():
  a command byte out, then the addressed status byte back in.
  Assumes mode 0 on the far side and an 80 ns link clock period.
*/
`timescale 1ns/1ps
module spi_host_model
(
  output logic      sck_out,
  output logic      chip_select_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  // Half of the 80 ns link clock period
  localparam time HALF = 40ns;

  // Link clock stands still low and select stays high between frames
  initial
  begin
    sck_out           = 1'b0;
    chip_select_n_out = 1'b0;
    mosi_out          = 1'b0;
    // A rising select edge clears the link bit counter, shift and answer flops, which have no other reset
    #1;
    chip_select_n_out = 1'b1;
  end

  // host issues read and read-and-clear frames
  task automatic frame(input logic [7:0] cmd, output logic [7:0] data);
    // Odd offset keeps the link edges apart from the core clock edges
    #13;
    chip_select_n_out = 1'b0;
    // Select leads the first rising edge by well over four core cycles
    #160;
    for (int i = 0; i < 16; i++)
    begin
      // Data byte in is ignored, so the line toggles rather than repeats
      mosi_out = (i < 8) ? cmd[7-i] : ~mosi_out;
      #HALF;
      sck_out = 1'b1;
      // Answer bit is settled from the previous falling edge
      if (i >= 8)
        data[15-i] = miso_in;
      #HALF;
      sck_out = 1'b0;
    end
    #HALF;
    chip_select_n_out = 1'b1;
    // Released line shows the inverse of its last value
    mosi_out = ~mosi_out;
    // Select stays high well beyond four core cycles between frames
    #200;
  endtask
endmodule // spi_host_model

/* bench/channel_fault_status_regs_tb_top.sv */
/*
  Testbench for the channel fault status register bank: detector and
  channel stimulus at the core clock, status read and cleared over SPI.
  Assumes the SPI host model drives the link and the short delay value.
*/
`timescale 1ns/1ps
module channel_fault_status_regs_tb_top;
  import fault_regs_pkg::*;

  // Short off-state delay keeps the run brief
  localparam int unsigned DLY = 8;

  logic              clk_in     = 1'b0;  // Core clock
  logic              rst_in     = 1'b0;  // Reset, raised at 1 ns; synchronous in the core, asynchronous for the link command flops
  logic              sck;                // Link clock from host
  logic              chip_select_n;                // Select from host, active low
  logic              mosi;               // Command line
  logic              miso;               // Answer line
  logic              miso_oe;            // Answer enable
  logic [NUM_CH-1:0] ch_on      = 4'hf;  // All channels on at start
  logic [NUM_CH-1:0] cfg        = 4'h0;  // Detector choice per channel
  logic [NUM_CH-1:0] ol_det     = 4'h0;  // Open-load detectors
  logic [NUM_CH-1:0] stk_det    = 4'h0;  // Stuck detectors
  logic [NUM_CH-1:0] pwl        = 4'h0;  // Power limit conditions
  logic [NUM_CH-1:0] ovl        = 4'h0;  // Overload detectors
  logic              latch      = 1'b1;  // Latch protection mode
  logic [REG_W-1:0]  st_off;             // Off-state status
  logic [REG_W-1:0]  st_pwl;             // Power limit status
  logic [REG_W-1:0]  st_ovl;             // Overload status
  logic [REG_W-1:0]  rdata;              // Last byte read
  int                errors     = 0;     // Mismatch count
  int                n_compared = 0;     // Comparison count
  int                cycles     = 0;     // Watchdog count

  // Core clock, 20 ns period
  always #10 clk_in = ~clk_in;

  channel_fault_status_regs #(.DELAY_CYC(DLY)) channel_fault_status_regs_inst
  (
    .clk_in                      (clk_in),
    .rst_in                      (rst_in),
    .sck_in                      (sck),
    .chip_select_n_in            (chip_select_n),
    .mosi_in                     (mosi),
    .miso_out                    (miso),
    .miso_oe_out                 (miso_oe),
    .channel_on_in               (ch_on),
    .offstate_openload_config_in (cfg),
    .offstate_openload_det_in    (ol_det),
    .offstate_stuck_det_in       (stk_det),
    .latch_mode_in               (latch),
    .power_limit_condition_in    (pwl),
    .overload_det_in             (ovl),
    .offstate_status_out         (st_off),
    .power_limit_status_out      (st_pwl),
    .overload_status_out         (st_ovl)
  );

  spi_host_model spi_host_model_inst
  (
    .sck_out           (sck),
    .chip_select_n_out (chip_select_n),
    .mosi_out          (mosi),
    .miso_in           (miso)
  );

  // Verdict and end of run, reached from the sequence and the watchdog
  task automatic end_of_test;
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // After the reset rise, core-side inputs move only at falling edges of the core clock
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Four-state compare so an unknown never matches
  task automatic chk(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One frame, its answer compared, then time for the frame end to land
  task automatic spi(input logic [1:0] op, input logic [5:0] addr, input logic [REG_W-1:0] exp);
    spi_host_model_inst.frame({op, addr}, rdata);
    chk(rdata, exp);
    wait_clk(10);
  endtask

  // Watchdog: the sequence needs a few thousand cycles at most
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  initial
  begin
    // An initialiser gives no edge; the async link flops need a real one
    #1;
    rst_in = 1'b1;
    wait_clk(20);
    rst_in = 1'b0;
    wait_clk(5);
    // Reset values, reserved bits and an unmapped address
    spi(OP_READ, ADDR_OFFSTATE, RESET_STATUS);
    spi(OP_READ, ADDR_PWL, RESET_STATUS);
    spi(OP_READ, ADDR_OVL, RESET_STATUS);
    spi(OP_READ, 6'h35, 8'h00);
    // Channels 0 and 1 off, each with its own detector choice
    cfg     = 4'h2;
    ol_det  = 4'h1;
    stk_det = 4'h2;
    ch_on   = 4'hc;
    wait_clk(DLY - 3);
    chk(st_off, 8'h00);
    wait_clk(11);
    chk(st_off, 8'h03);
    // Bit follows the detector while off, holds once on
    ol_det = 4'h0;
    wait_clk(6);
    chk(st_off, 8'h02);
    ch_on = 4'hf;
    wait_clk(2);
    stk_det = 4'h0;
    wait_clk(6);
    chk(st_off, 8'h02);
    spi(OP_READ_CLEAR, ADDR_OFFSTATE, 8'h02);
    chk(st_off, 8'h00);
    // Latch mode: a pulse sets, a plain read leaves, read-and-clear clears
    pwl = 4'h4;
    wait_clk(6);
    pwl = 4'h0;
    wait_clk(6);
    chk(st_pwl, 8'h04);
    spi(OP_READ, ADDR_PWL, 8'h04);
    chk(st_pwl, 8'h04);
    spi(OP_READ_CLEAR, ADDR_PWL, 8'h04);
    chk(st_pwl, 8'h00);
    // Condition still present wins over the clear
    pwl = 4'h2;
    wait_clk(6);
    spi(OP_READ_CLEAR, ADDR_PWL, 8'h02);
    chk(st_pwl, 8'h02);
    pwl = 4'h0;
    wait_clk(6);
    spi(OP_READ_CLEAR, ADDR_PWL, 8'h02);
    // Auto-restart: held while off, gone once on without a command
    latch = 1'b0;
    ch_on = 4'h7;
    wait_clk(2);
    pwl = 4'h8;
    wait_clk(6);
    pwl = 4'h0;
    wait_clk(6);
    chk(st_pwl, 8'h08);
    ch_on = 4'hf;
    wait_clk(6);
    chk(st_pwl, 8'h00);
    // overload set while on; its read-and-clear takes effect only after a turn-off
    ovl = 4'h1;
    wait_clk(6);
    ovl = 4'h0;
    wait_clk(6);
    chk(st_ovl, 8'h01);
    spi(OP_READ_CLEAR, ADDR_OVL, 8'h01);
    chk(st_ovl, 8'h01);
    ch_on = 4'he;
    wait_clk(4);
    ch_on = 4'hf;
    wait_clk(6);
    spi(OP_READ_CLEAR, ADDR_OVL, 8'h01);
    chk(st_ovl, 8'h00);
    // Events and a turn-off arriving in mid-frame
    latch = 1'b1;
    ovl   = 4'h2;
    wait_clk(6);
    ovl = 4'h0;
    wait_clk(6);
    fork
      spi_host_model_inst.frame({OP_READ, ADDR_PWL}, rdata);
      begin
        wait_clk(12);
        pwl   = 4'h1;
        ch_on = 4'hd;
        wait_clk(4);
        ch_on = 4'hf;
        wait_clk(6);
        pwl = 4'h0;
        chk(st_pwl, 8'h00);
        chk({7'h00, miso_oe}, 8'h01);
      end
    join
    chk(rdata, 8'h00);
    chk({7'h00, miso_oe}, 8'h00);
    wait_clk(10);
    chk(st_pwl, 8'h01);
    spi(OP_READ_CLEAR, ADDR_OVL, 8'h02);
    chk(st_ovl, 8'h02);
    spi(OP_READ_CLEAR, ADDR_PWL, 8'h01);
    chk(st_pwl, 8'h00);
    end_of_test();
  end
endmodule // channel_fault_status_regs_tb_top
